// ===== hw/dsr_core.sv
// Deep sleep release and identifier read command logic
// Summary of operation
// - A release opcode wakes the device from deep sleep in both plain and identifier forms.
// - After the wake frame ends the device becomes ready once the recovery time has run out.
// - In identifier form the device drives the identifier, changing on falling clock edges.
// - The identifier streams while chip select stays low and the frame end stops it.
// - With supply below threshold the sleep state freezes and commands are ignored, but a running recovery countdown continues.
// - In deep sleep every instruction but the release opcode is ignored.
// - Recovery from chip select rise to readiness takes the 10 microsecond countdown plus four reference clock cycles.
`timescale 1ns/1ps
module dsr_core #(
  parameter int ID_W         = dsr_pkg::ID_WIDTH,
  parameter int RECOVERY_CYC = dsr_pkg::RECOVERY_CYCLES
) (
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  input  wire logic            sck,
  input  wire logic            cs_n,
  input  wire logic [3:0]      dq_in,
  input  wire logic            quad_line_mode,
  input  wire logic            supply_ok,
  input  wire logic [ID_W-1:0] device_id,
  output logic [3:0]           dq_out,
  output logic [3:0]           dq_oe_n,
  output logic                 deep_sleep_mode,
  output logic                 ready
);
  initial begin
    if (RECOVERY_CYC < 1 || RECOVERY_CYC > 65535) $error("RECOVERY_CYC out of range");
  end

  logic              accept_r;
  logic              evt_toggle;
  dsr_pkg::dsr_evt_t evt;
  logic [3:0]        dq_out_w;
  logic [3:0]        dq_oe_n_w;
  logic [2:0]        tog_sync_r;
  logic [1:0]        sup_sync_r;
  logic [1:0]        cs_sync_r;
  logic [15:0]       rec_cnt_r;
  logic              sleep_r;
  logic              wake_pulse;
  logic              sleep_pulse;

  dsr_link #(.ID_W(ID_W)) u_link (
    .sck            (sck),
    .cs_n           (cs_n),
    .reset_n        (reset_n),
    .quad_line_mode (quad_line_mode),
    .accept         (accept_r),
    .device_id      (device_id),
    .dq_in          (dq_in),
    .dq_out         (dq_out_w),
    .dq_oe_n        (dq_oe_n_w),
    .evt_toggle     (evt_toggle),
    .evt            (evt)
  );

  // Toggle crossing; event fields settle long before the toggle is seen
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_sync_r <= 3'b000;
      sup_sync_r <= 2'b00;
      cs_sync_r  <= 2'b11;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], evt_toggle};
      sup_sync_r <= {sup_sync_r[0], supply_ok};
      cs_sync_r  <= {cs_sync_r[0], cs_n};
    end
  end

  assign wake_pulse  = (tog_sync_r[2] ^ tog_sync_r[1]) && evt.cmd == dsr_pkg::DSR_CMD_WAKE;
  assign sleep_pulse = (tog_sync_r[2] ^ tog_sync_r[1]) && evt.cmd == dsr_pkg::DSR_CMD_SLEEP;

  // Sleep state; only release acts while asleep
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_r <= 1'b0;
    end else if (!sup_sync_r[1]) begin
      sleep_r <= sleep_r;
    end else if (wake_pulse) begin
      sleep_r <= 1'b0;
    end else if (sleep_pulse && !sleep_r) begin
      sleep_r <= 1'b1;
    end
  end

  // Recovery countdown after a wake frame ends
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_cnt_r <= 16'h0000;
    end else if (wake_pulse && sup_sync_r[1]) begin
      rec_cnt_r <= 16'(RECOVERY_CYC - 1);
    end else if (rec_cnt_r != 16'h0000) begin
      rec_cnt_r <= rec_cnt_r - 16'h0001;
    end
  end

  // Link accepts commands only with good supply and no pending recovery
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      accept_r <= 1'b0;
    end else if (cs_sync_r[1]) begin
      // Wake term drops accept at once, so ready shows no pulse before recovery
      accept_r <= sup_sync_r[1] && rec_cnt_r == 16'h0000 && !wake_pulse;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      deep_sleep_mode <= 1'b0;
      ready           <= 1'b0;
    end else begin
      deep_sleep_mode <= sleep_r;
      ready           <= accept_r && !sleep_r;
    end
  end

  // Pin drivers live on the link clock; they leave straight from link flops
  assign dq_out  = dq_out_w;
  assign dq_oe_n = dq_oe_n_w;

  a_wake_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wake_pulse && sup_sync_r[1]) |=> !sleep_r) else $error("wake lost");
  a_sleep_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleep_r && !wake_pulse) |=> sleep_r) else $error("sleep left without release");
  a_rec_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wake_pulse && sup_sync_r[1]) |=> rec_cnt_r == 16'(RECOVERY_CYC - 1))
    else $error("recovery not loaded");
  a_rec_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rec_cnt_r <= 16'(RECOVERY_CYC - 1)) else $error("recovery too long");
  a_rec_down: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rec_cnt_r != 16'h0000 && !wake_pulse) |=> rec_cnt_r == $past(rec_cnt_r) - 16'h0001)
    else $error("recovery stalled");
  a_supply_block: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!sup_sync_r[1] && cs_sync_r[1]) |=> !accept_r) else $error("accept at low supply");
  a_supply_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !sup_sync_r[1] |=> $stable(sleep_r)) else $error("state moved at low supply");
  a_ready_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ready |-> $past(accept_r) && !$past(sleep_r)) else $error("ready wrong");
  a_sleep_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_pulse && !sleep_r && sup_sync_r[1] |-> ##2 deep_sleep_mode)
    else $error("sleep not shown");

  c_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) sleep_r ##1 !sleep_r);
  c_sleep: cover property (@(posedge ref_clk) disable iff (!reset_n) !sleep_r ##1 sleep_r);
  c_id_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) wake_pulse && evt.id_form);
  c_ready: cover property (@(posedge ref_clk) disable iff (!reset_n) rec_cnt_r == 16'h0001 ##1 1'b1);
endmodule : dsr_core

// ===== hw/dsr_pkg.sv
// Package for the deep sleep release and identifier read block
package dsr_pkg;
  localparam logic [7:0] RELEASE_OPCODE   = 8'hAB;
  localparam logic [7:0] SLEEP_OPCODE     = 8'hB9;
  localparam int         DUMMY_CLOCKS     = 3;
  localparam int         RECOVERY_TIME_NS = 10000;
  localparam int         REF_PERIOD_NS    = 10;
  localparam int         RECOVERY_CYCLES  = RECOVERY_TIME_NS / REF_PERIOD_NS;
  localparam int         ID_WIDTH         = 24;
  localparam logic [23:0] ID_DEFAULT      = 24'h00_5A5A; // Arbitrary value

  typedef enum logic [1:0] {DSR_CMD_NONE, DSR_CMD_WAKE, DSR_CMD_SLEEP} dsr_cmd_t;

  // Event carried from the link domain to the core domain
  typedef struct packed {
    dsr_cmd_t cmd;
    logic     id_form;
  } dsr_evt_t;
endpackage : dsr_pkg

// ===== hw/dsr_link.sv
// Link side shifter: opcode capture and identifier streaming on the serial clock
`timescale 1ns/1ps
module dsr_link #(
  parameter int ID_W = dsr_pkg::ID_WIDTH
) (
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              reset_n,
  input  wire logic              quad_line_mode,
  input  wire logic              accept,
  input  wire logic [ID_W-1:0]   device_id,
  input  wire logic [3:0]        dq_in,
  output logic [3:0]             dq_out,
  output logic [3:0]             dq_oe_n,
  output logic                   evt_toggle,
  output dsr_pkg::dsr_evt_t      evt
);
  initial begin
    if (ID_W % 8 != 0 || ID_W < 8) $error("ID_W must be whole bytes");
  end

  logic [7:0]      op_r;
  logic [3:0]      cnt_r;
  logic            got_op_r;
  logic [2:0]      dummy_r;
  logic [ID_W-1:0] sh_r;
  logic            drive_r;
  logic [7:0]      op_nxt;

  always_comb begin
    op_nxt = quad_line_mode ? {op_r[3:0], dq_in} : {op_r[6:0], dq_in[0]};
  end

  // Frame state cleared by chip select itself since the clock stops outside frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      op_r     <= 8'h00;
      cnt_r    <= 4'h0;
      got_op_r <= 1'b0;
      dummy_r  <= 3'h0;
    end else if (!got_op_r) begin
      op_r  <= op_nxt;
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == (quad_line_mode ? 4'h1 : 4'h7)) begin
        got_op_r <= 1'b1;
      end
    end else if (dummy_r != 3'(dsr_pkg::DUMMY_CLOCKS)) begin
      dummy_r <= dummy_r + 3'h1;
    end
  end

  // Opcode seen at cs rise is reported once per frame
  // Reset needed: an unknown toggle would never resolve across the crossing
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      evt_toggle  <= 1'b0;
      evt.cmd     <= dsr_pkg::DSR_CMD_NONE;
      evt.id_form <= 1'b0;
    end else if (accept && got_op_r) begin
      evt_toggle  <= ~evt_toggle;
      evt.cmd     <= (op_r == dsr_pkg::RELEASE_OPCODE) ? dsr_pkg::DSR_CMD_WAKE :
                     (op_r == dsr_pkg::SLEEP_OPCODE) ? dsr_pkg::DSR_CMD_SLEEP :
                     dsr_pkg::DSR_CMD_NONE;
      evt.id_form <= dummy_r != 3'h0;
    end
  end

  // Output changes on falling edges after the dummy clocks
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      drive_r <= 1'b0;
      sh_r    <= device_id;
    end else if (accept && got_op_r && op_r == dsr_pkg::RELEASE_OPCODE &&
                 dummy_r == 3'(dsr_pkg::DUMMY_CLOCKS)) begin
      drive_r <= 1'b1;
      if (drive_r) begin
        sh_r <= quad_line_mode ? {sh_r[ID_W-5:0], sh_r[ID_W-1:ID_W-4]}
                               : {sh_r[ID_W-2:0], sh_r[ID_W-1]};
      end
    end
  end

  always_comb begin
    dq_out  = quad_line_mode ? sh_r[ID_W-1:ID_W-4] : {2'b00, sh_r[ID_W-1], 1'b0};
    dq_oe_n = !drive_r ? 4'hF : (quad_line_mode ? 4'h0 : 4'hD);
  end
endmodule : dsr_link

// ===== bench/dsr_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module dsr_host (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      dq_in,
  input  wire logic       quad,
  input  wire logic [3:0] dq_out
);
  logic [47:0] rx;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'h0;
  end
  // Clock stands still outside frames; released data toggles so no stale value reads as valid
  task automatic frame(input logic [7:0] op, input int n_dum, input int n_rd);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < (quad ? 2 : 8); i++) begin
      dq_in = quad ? (i ? op[3:0] : op[7:4]) : {3'h0, op[7-i]};
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    for (i = 0; i < n_dum + n_rd; i++) begin
      dq_in = ~dq_in;
      #62.5 sck = 1'b1;
      if (i >= n_dum) rx = quad ? {rx[43:0], dq_out} : {rx[46:0], dq_out[1]};
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    dq_in = ~dq_in;
  endtask : frame
endmodule : dsr_host

// ===== bench/tb_deep_sleep_release_id_read.sv
// Self-checking bench for the deep sleep release block
`timescale 1ns/1ps
module tb_deep_sleep_release_id_read;
  localparam int          REC = 20;
  localparam logic [23:0] ID  = 24'h00_5A5A; // Arbitrary value
  logic       ref_clk, reset_n, sck, cs_n, quad, supply_ok, deep_sleep_mode, ready;
  logic [3:0] dq_in, dq_out, dq_oe_n;
  int         n_fail, n_tests, cnt;
  dsr_core #(.ID_W(24), .RECOVERY_CYC(REC)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .sck(sck), .cs_n(cs_n), .dq_in(dq_in), .quad_line_mode(quad), .supply_ok(supply_ok),
    .device_id(ID), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .deep_sleep_mode(deep_sleep_mode),
    .ready(ready));
  dsr_host u_host (.sck(sck), .cs_n(cs_n), .dq_in(dq_in), .quad(quad), .dq_out(dq_out));
  always #5 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_ready();
    cnt = 0;
    while (ready !== 1'b1 && cnt < 500) begin
      @(posedge ref_clk);
      cnt++;
    end
    #1;
    if (cnt == 500) begin
      chk(0, 1);
      finish_test();
    end
  endtask : wait_ready
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic t_sleep(input logic q);
    quad = q;
    u_host.frame(8'hB9, 0, 0);
    settle();
    chk(deep_sleep_mode, 1);
    chk(ready, 0);
  endtask : t_sleep
  task automatic t_ignored();
    u_host.frame(8'h05, 0, 0);
    settle();
    chk(deep_sleep_mode, 1);
    chk(ready, 0);
  endtask : t_ignored
  task automatic t_wake(input logic q, input logic rd);
    quad = q;
    u_host.frame(8'hAB, rd ? 3 : 0, rd ? (q ? 12 : 48) : 0);
    settle();
    chk(deep_sleep_mode, 0);
    chk(ready, 0);
    chk(dq_oe_n, 4'hF);
    wait_ready();
    chk(cnt >= REC - 10 && cnt <= REC + 6, 1);
    if (rd) chk(u_host.rx, {ID, ID});
  endtask : t_wake
  task automatic t_supply();
    supply_ok = 1'b0;
    repeat (4) @(posedge ref_clk);
    u_host.frame(8'hB9, 0, 0);
    settle();
    supply_ok = 1'b1;
    wait_ready();
    chk(deep_sleep_mode, 0);
  endtask : t_supply
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    supply_ok = 1'b1;
    quad = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    wait_ready();
    t_sleep(0);
    t_ignored();
    t_wake(0, 0);
    t_sleep(1);
    t_wake(1, 1);
    t_sleep(0);
    t_wake(0, 1);
    t_wake(1, 0);
    t_supply();
    finish_test();
  end
endmodule : tb_deep_sleep_release_id_read
